// ### pkg/iod_pkg.sv
// Package with the I/O register map, field masks and access types of the register decoder.
package iod_pkg;
   // ==========================================================
   // Address spaces
   // ==========================================================
   localparam logic [7:0] IOD_DATA_OFS = 8'h20;
   localparam logic [5:0] IOD_BIT_TOP = 6'h1f;
   localparam logic [7:0] IOD_EXT_LO = 8'h60;
   localparam logic [7:0] IOD_EXT_HI = 8'hff;
   localparam int IOD_IO_LOCS = 64;
   // ==========================================================
   // Register offsets (I/O addresses)
   // ==========================================================
   localparam logic [5:0] PORT_B_INPUT_PINS = 6'h03;
   localparam logic [5:0] PORT_B_DIRECTION = 6'h04;
   localparam logic [5:0] PORT_B_OUTPUT_LATCH = 6'h05;
   localparam logic [5:0] PORT_C_INPUT_PINS = 6'h06;
   localparam logic [5:0] PORT_C_DIRECTION = 6'h07;
   localparam logic [5:0] PORT_C_OUTPUT_LATCH = 6'h08;
   localparam logic [5:0] PORT_D_INPUT_PINS = 6'h09;
   localparam logic [5:0] PORT_D_DIRECTION = 6'h0a;
   localparam logic [5:0] PORT_D_OUTPUT_LATCH = 6'h0b;
   localparam logic [5:0] TIMER0_EVENT_FLAGS = 6'h15;
   localparam logic [5:0] TIMER1_EVENT_FLAGS = 6'h16;
   localparam logic [5:0] TIMER2_EVENT_FLAGS = 6'h17;
   localparam logic [5:0] PIN_CHANGE_FLAGS = 6'h1b;
   localparam logic [5:0] EXTERNAL_IRQ_FLAGS = 6'h1c;
   localparam logic [5:0] EXTERNAL_IRQ_MASK = 6'h1d;
   localparam logic [5:0] SCRATCH_REG_0 = 6'h1e;
   localparam logic [5:0] EEPROM_CONTROL = 6'h1f;
   localparam logic [5:0] EEPROM_DATA = 6'h20;
   localparam logic [5:0] EEPROM_ADDRESS_LOW = 6'h21;
   localparam logic [5:0] EEPROM_ADDRESS_HIGH = 6'h22;
   localparam logic [5:0] TIMER_SHARED_CONTROL = 6'h23;
   localparam logic [5:0] TIMER0_CONTROL_A = 6'h24;
   localparam logic [5:0] TIMER0_CONTROL_B = 6'h25;
   localparam logic [5:0] TIMER0_COUNT = 6'h26;
   localparam logic [5:0] TIMER0_COMPARE_A = 6'h27;
   localparam logic [5:0] TIMER0_COMPARE_B = 6'h28;
   localparam logic [5:0] SCRATCH_REG_1 = 6'h2a;
   localparam logic [5:0] SCRATCH_REG_2 = 6'h2b;
   localparam logic [5:0] SERIAL_PERIPH_CONTROL = 6'h2c;
   localparam logic [5:0] SERIAL_PERIPH_STATUS = 6'h2d;
   localparam logic [5:0] SERIAL_PERIPH_DATA = 6'h2e;
   localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h30;
   localparam logic [5:0] SLEEP_MODE_CONTROL = 6'h33;
   localparam logic [5:0] RESET_CAUSE_STATUS = 6'h34;
   localparam logic [5:0] CORE_CONTROL = 6'h35;
   localparam logic [5:0] SELF_PROGRAM_CONTROL = 6'h37;
   // ==========================================================
   // Writable bit masks (reserved bits are zero)
   // ==========================================================
   localparam logic [7:0] MASK_ALL = 8'hff;
   localparam logic [7:0] MASK_PORT_C = 8'h7f;
   localparam logic [7:0] MASK_T0_FLAGS = 8'h07;
   localparam logic [7:0] MASK_T1_FLAGS = 8'h27;
   localparam logic [7:0] MASK_T2_FLAGS = 8'h07;
   localparam logic [7:0] MASK_PC_FLAGS = 8'h07;
   localparam logic [7:0] MASK_EXT_FLAGS = 8'h03;
   localparam logic [7:0] MASK_EXT_IRQ = 8'h03;
   localparam logic [7:0] MASK_EE_CTRL = 8'h3f;
   localparam logic [7:0] MASK_TSHARED = 8'h83;
   localparam logic [7:0] MASK_T0_CTRL_A = 8'hf3;
   localparam logic [7:0] MASK_T0_CTRL_B = 8'hcf;
   localparam logic [7:0] MASK_SP_STATUS = 8'h01;
   localparam logic [7:0] MASK_SP_FLAGS = 8'hc0;
   localparam logic [7:0] MASK_CMP_RW = 8'hcf;
   localparam logic [7:0] MASK_CMP_FLAG = 8'h10;
   localparam logic [7:0] MASK_SLEEP = 8'h0f;
   localparam logic [7:0] MASK_RESET_CAUSE = 8'h0f;
   localparam logic [7:0] MASK_CORE = 8'h73;
   localparam logic [7:0] MASK_SELF_PROG = 8'hdf;
   localparam logic [7:0] IOD_RESET_VAL = 8'h00;
   // ==========================================================
   // Access types
   // ==========================================================
   typedef enum logic [2:0]
   {
      IOD_OP_NONE = 3'b000,
      IOD_OP_IN = 3'b001,
      IOD_OP_OUT = 3'b010,
      IOD_OP_SET_BIT = 3'b011,
      IOD_OP_CLR_BIT = 3'b100,
      IOD_OP_TEST_BIT = 3'b101,
      IOD_OP_LOAD = 3'b110,
      IOD_OP_STORE = 3'b111
   } iod_op_t;

   typedef struct packed
   {
      iod_op_t op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iod_req_t;
endpackage : iod_pkg

// ### hdl/iod_decoder.sv
// I/O register space decoder and register bank facing the processor core.
// Function
// - Bit set/clear works on 0x00..0x1F.
// - Bit test returns one bit, lower range.
// - Writing one clears a flag; zero keeps.
// - Bit set/clear touches only addressed bit.
// - Direct I/O uses addresses 0x00..0x3F.
// - Data address equals I/O address plus 0x20.
// - Direct I/O reaches exactly 64 locations.
// - Extended 0x60..0xFF only via load/store.
module iod_decoder
   import iod_pkg::*;
#(
   parameter int REGS = IOD_IO_LOCS
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire iod_req_t req_in,
   input wire logic [7:0] pin_b_in,
   input wire logic [7:0] pin_c_in,
   input wire logic [7:0] pin_d_in,
   input wire logic [7:0] t0_set_in,
   input wire logic [7:0] t1_set_in,
   input wire logic [7:0] t2_set_in,
   input wire logic [7:0] pc_set_in,
   input wire logic [7:0] ext_set_in,
   input wire logic [7:0] sp_set_in,
   input wire logic [7:0] cmp_set_in,
   input wire logic [7:0] rst_cause_set_in,
   input wire logic [7:0] ext_rdata_in,
   output logic [7:0] rdata_out,
   output logic bit_out,
   output logic ext_rd_out,
   output logic ext_wr_out,
   output logic [7:0] ext_addr_out,
   output logic [7:0] ext_wdata_out,
   output logic [7:0] regs_out [REGS]
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [7:0] pin_s1_q [3];
   logic [7:0] pin_s2_q [3];
   logic [7:0] pin_s3_q [3];
   logic [7:0] pin_raw [3];
   logic [7:0] pin_val_q [3];
   assign pin_raw[0] = pin_b_in;
   assign pin_raw[1] = pin_c_in;
   assign pin_raw[2] = pin_d_in;

   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++)
      begin : g_pin
         always_ff @(posedge clk_in)
         begin
            pin_s1_q[gp] <= pin_raw[gp];
            pin_s2_q[gp] <= pin_s1_q[gp];
            pin_s3_q[gp] <= pin_s2_q[gp];
            if (rst_in)
               pin_val_q[gp] <= IOD_RESET_VAL;
            else if (pin_s2_q[gp] == pin_s3_q[gp])
               pin_val_q[gp] <= pin_s3_q[gp];
         end
      end
   endgenerate

   // ==========================================================
   // Address translation
   // ==========================================================
   wire is_io_op = (req_in.op == IOD_OP_IN) || (req_in.op == IOD_OP_OUT);
   wire is_bit_op = (req_in.op == IOD_OP_SET_BIT) || (req_in.op == IOD_OP_CLR_BIT)
                    || (req_in.op == IOD_OP_TEST_BIT);
   wire is_ld_st = (req_in.op == IOD_OP_LOAD) || (req_in.op == IOD_OP_STORE);
   // Direct I/O keeps only six address bits, so 64 locations are all it reaches.
   wire [5:0] io_addr = req_in.addr[5:0];
   wire [7:0] data_rel = req_in.addr - IOD_DATA_OFS;
   wire ld_st_io = is_ld_st && (req_in.addr >= IOD_DATA_OFS) && (req_in.addr < IOD_EXT_LO);
   wire ld_st_ext = is_ld_st && (req_in.addr >= IOD_EXT_LO) && (req_in.addr <= IOD_EXT_HI);
   wire bit_ok = is_bit_op && (io_addr <= IOD_BIT_TOP);
   wire [5:0] reg_idx = ld_st_io ? data_rel[5:0] : io_addr;
   wire acc_sel = is_io_op || bit_ok || ld_st_io;
   wire wr_word = acc_sel && ((req_in.op == IOD_OP_OUT) || (req_in.op == IOD_OP_STORE));
   wire wr_set = bit_ok && (req_in.op == IOD_OP_SET_BIT);
   wire wr_clr = bit_ok && (req_in.op == IOD_OP_CLR_BIT);
   wire [7:0] bit_onehot = 8'h01 << req_in.bit_sel;

   // ==========================================================
   // Register attributes
   // ==========================================================
   function automatic logic [7:0] rw_mask(input logic [5:0] a);
      unique case (a)
         PORT_B_DIRECTION, PORT_B_OUTPUT_LATCH, PORT_D_DIRECTION, PORT_D_OUTPUT_LATCH,
         SCRATCH_REG_0, EEPROM_DATA, EEPROM_ADDRESS_LOW, EEPROM_ADDRESS_HIGH,
         TIMER0_COUNT, TIMER0_COMPARE_A, TIMER0_COMPARE_B, SCRATCH_REG_1,
         SCRATCH_REG_2, SERIAL_PERIPH_CONTROL, SERIAL_PERIPH_DATA: rw_mask = MASK_ALL;
         PORT_C_DIRECTION, PORT_C_OUTPUT_LATCH: rw_mask = MASK_PORT_C;
         EXTERNAL_IRQ_MASK: rw_mask = MASK_EXT_IRQ;
         EEPROM_CONTROL: rw_mask = MASK_EE_CTRL;
         TIMER_SHARED_CONTROL: rw_mask = MASK_TSHARED;
         TIMER0_CONTROL_A: rw_mask = MASK_T0_CTRL_A;
         TIMER0_CONTROL_B: rw_mask = MASK_T0_CTRL_B;
         SERIAL_PERIPH_STATUS: rw_mask = MASK_SP_STATUS;
         COMPARATOR_CONTROL_STATUS: rw_mask = MASK_CMP_RW;
         SLEEP_MODE_CONTROL: rw_mask = MASK_SLEEP;
         CORE_CONTROL: rw_mask = MASK_CORE;
         SELF_PROGRAM_CONTROL: rw_mask = MASK_SELF_PROG;
         default: rw_mask = 8'h00;
      endcase
   endfunction : rw_mask

   function automatic logic [7:0] w1c_mask(input logic [5:0] a);
      unique case (a)
         TIMER0_EVENT_FLAGS: w1c_mask = MASK_T0_FLAGS;
         TIMER1_EVENT_FLAGS: w1c_mask = MASK_T1_FLAGS;
         TIMER2_EVENT_FLAGS: w1c_mask = MASK_T2_FLAGS;
         PIN_CHANGE_FLAGS: w1c_mask = MASK_PC_FLAGS;
         EXTERNAL_IRQ_FLAGS: w1c_mask = MASK_EXT_FLAGS;
         SERIAL_PERIPH_STATUS: w1c_mask = MASK_SP_FLAGS;
         COMPARATOR_CONTROL_STATUS: w1c_mask = MASK_CMP_FLAG;
         RESET_CAUSE_STATUS: w1c_mask = MASK_RESET_CAUSE;
         default: w1c_mask = 8'h00;
      endcase
   endfunction : w1c_mask

   function automatic logic [7:0] hw_set(input logic [5:0] a, input logic [7:0] t0,
                                         input logic [7:0] t1, input logic [7:0] t2,
                                         input logic [7:0] pc, input logic [7:0] ex,
                                         input logic [7:0] sp, input logic [7:0] cm,
                                         input logic [7:0] rc);
      unique case (a)
         TIMER0_EVENT_FLAGS: hw_set = t0;
         TIMER1_EVENT_FLAGS: hw_set = t1;
         TIMER2_EVENT_FLAGS: hw_set = t2;
         PIN_CHANGE_FLAGS: hw_set = pc;
         EXTERNAL_IRQ_FLAGS: hw_set = ex;
         SERIAL_PERIPH_STATUS: hw_set = sp;
         COMPARATOR_CONTROL_STATUS: hw_set = cm;
         RESET_CAUSE_STATUS: hw_set = rc;
         default: hw_set = 8'h00;
      endcase
   endfunction : hw_set

   // ==========================================================
   // Register bank
   // ==========================================================
   logic [7:0] reg_q [REGS];

   genvar gr;
   generate
      for (gr = 0; gr < REGS; gr++)
      begin : g_reg
         localparam logic [5:0] A = 6'(gr);
         localparam logic [7:0] RWM = rw_mask(A);
         localparam logic [7:0] W1M = w1c_mask(A);
         wire hit = (reg_idx == A);
         wire [7:0] set_in = hw_set(A, t0_set_in, t1_set_in, t2_set_in, pc_set_in,
                                    ext_set_in, sp_set_in, cmp_set_in, rst_cause_set_in);
         wire [7:0] w_word = (hit && wr_word) ? req_in.wdata : 8'h00;
         wire [7:0] w_set = (hit && wr_set) ? bit_onehot : 8'h00;
         wire [7:0] w_clr = (hit && wr_clr) ? bit_onehot : 8'h00;
         // Bit set/clear changes only the addressed bit, never clears a flag as a side effect.
         wire [7:0] rw_d = (hit && wr_word) ? (req_in.wdata & RWM)
                           : ((reg_q[gr] | w_set) & ~w_clr & RWM);
         // A one clears a flag; a bit set also clears it, the only bit it touches. Set wins.
         wire [7:0] fl_clr = (w_word | w_set) & W1M;
         wire [7:0] fl_d = ((reg_q[gr] & ~fl_clr) | set_in) & W1M;
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
               reg_q[gr] <= IOD_RESET_VAL;
            else
               reg_q[gr] <= rw_d | fl_d;
         end
      end
   endgenerate

   // ==========================================================
   // Read path
   // ==========================================================
   wire is_pin_b = (reg_idx == PORT_B_INPUT_PINS);
   wire is_pin_c = (reg_idx == PORT_C_INPUT_PINS);
   wire is_pin_d = (reg_idx == PORT_D_INPUT_PINS);
   wire [7:0] rd_val = is_pin_b ? pin_val_q[0]
                     : is_pin_c ? (pin_val_q[1] & MASK_PORT_C)
                     : is_pin_d ? pin_val_q[2]
                     : reg_q[reg_idx];
   wire rd_word = acc_sel && ((req_in.op == IOD_OP_IN) || (req_in.op == IOD_OP_LOAD));
   wire rd_bit = bit_ok && (req_in.op == IOD_OP_TEST_BIT);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rdata_out <= 8'h00;
         bit_out <= 1'b0;
      end
      else
      begin
         rdata_out <= rd_word ? rd_val : (ld_st_ext ? ext_rdata_in : 8'h00);
         bit_out <= rd_bit ? rd_val[req_in.bit_sel] : 1'b0;
      end
   end

   // Extended space is forwarded only for load and store.
   assign ext_rd_out = ld_st_ext && (req_in.op == IOD_OP_LOAD);
   assign ext_wr_out = ld_st_ext && (req_in.op == IOD_OP_STORE);
   assign ext_addr_out = ld_st_ext ? req_in.addr : 8'h00;
   assign ext_wdata_out = ext_wr_out ? req_in.wdata : 8'h00;
   assign regs_out = reg_q;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Bank bit that a bit test should return, as it stands before the answer edge.
   wire test_bit_now = reg_q[io_addr][req_in.bit_sel];

   bit_test_value_a: assert property ((req_in.op == IOD_OP_TEST_BIT)
      && (req_in.addr[5:0] <= 6'h1f) && (req_in.addr[5:0] >= 6'h0c)
      |=> bit_out == $past(test_bit_now)) else $error("Bit test returned wrong value.");
   bit_test_upper_a: assert property ((req_in.op == IOD_OP_TEST_BIT)
      && (req_in.addr[5:0] > 6'h1f) |=> !bit_out)
      else $error("Bit test answered above lower range.");
   w1c_clear_a: assert property ((req_in.op == IOD_OP_OUT) && (req_in.addr[5:0] == 6'h1c)
      && req_in.wdata[0] && !ext_set_in[0] |=> !reg_q[28][0])
      else $error("Flag not cleared by one.");
   w1c_keep_a: assert property ((req_in.op == IOD_OP_OUT) && (req_in.addr[5:0] == 6'h1c)
      && !req_in.wdata[1] && reg_q[28][1] |=> reg_q[28][1])
      else $error("Flag cleared by zero.");
   bit_only_a: assert property ((req_in.op == IOD_OP_CLR_BIT)
      && (req_in.addr[5:0] == 6'h15) && (req_in.bit_sel != 3'h1) && reg_q[21][1]
      |=> reg_q[21][1]) else $error("Bit clear disturbed another flag.");
   bit_set_a: assert property ((req_in.op == IOD_OP_SET_BIT)
      && (req_in.addr[5:0] == 6'h05) |=> reg_q[5][$past(req_in.bit_sel)])
      else $error("Bit set missed.");
   data_map_a: assert property ((req_in.op == IOD_OP_STORE) && (req_in.addr == 8'h3e)
      |=> reg_q[30] == $past(req_in.wdata)) else $error("Data address map wrong.");
   io_map_a: assert property ((req_in.op == IOD_OP_OUT) && (req_in.addr[5:0] == 6'h2b)
      |=> reg_q[43] == $past(req_in.wdata)) else $error("I/O address map wrong.");
   ext_only_a: assert property (ext_rd_out || ext_wr_out
      |-> (req_in.op == IOD_OP_LOAD || req_in.op == IOD_OP_STORE) && req_in.addr >= 8'h60)
      else $error("Extended space reached wrongly.");
   reserved_zero_a: assert property (reg_q[54] == 8'h00 && (reg_q[8] & 8'h80) == 8'h00)
      else $error("Reserved bits not zero.");

   bit_set_c: cover property (req_in.op == IOD_OP_SET_BIT ##2 req_in.op == IOD_OP_TEST_BIT);
   w1c_c: cover property ((req_in.op == IOD_OP_OUT) && (req_in.addr[5:0] == 6'h15));
   ext_c: cover property (ext_wr_out ##4 ext_rd_out);
   load_c: cover property ((req_in.op == IOD_OP_LOAD) && ld_st_io);
endmodule : iod_decoder

// ### bench/iod_core_model.sv
// Processor core model that issues one register bank request at a time.
module iod_core_model
   import iod_pkg::*;
(
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic bit_in,
   output iod_req_t req_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial req_out = '0;

   function automatic logic reserved_io(input logic [5:0] a);
      return a <= 6'h02 || (a >= 6'h0c && a <= 6'h14) || (a >= 6'h18 && a <= 6'h1a)
         || a == 6'h29 || a == 6'h2f || a == 6'h31 || a == 6'h32 || a == 6'h36
         || (a >= 6'h38 && a <= 6'h3c);
   endfunction : reserved_io

   // Drives one request for one cycle (none for a write to a reserved I/O address) and returns what the bank answered.
   task automatic access(input iod_op_t op, input logic [7:0] addr, input logic [2:0] sel,
      input logic [7:0] wd, input logic [7:0] keep, output logic [7:0] rd, output logic bt);
      logic [5:0] io;
      logic wr;
      io = (op == IOD_OP_STORE) ? 6'(addr - 8'h20) : addr[5:0];
      wr = op inside {IOD_OP_OUT, IOD_OP_SET_BIT, IOD_OP_CLR_BIT}
         || (op == IOD_OP_STORE && addr >= 8'h20 && addr < 8'h60);
      @(posedge clk_in);
      if (!(wr && reserved_io(io)))
         req_out <= '{op: op, addr: addr, bit_sel: sel, wdata: wd & keep};
      @(posedge clk_in);
      req_out <= '0;
      #1;
      rd = rdata_in;
      bt = bit_in;
   endtask : access
endmodule : iod_core_model

// ### bench/tb_iod_decoder.sv
// Self-checking testbench of the I/O register decoder.
module tb_iod_decoder;
   import iod_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_in;
   logic rst_in = 1'b1;
   logic [7:0] pin_b = 8'h00;
   logic [7:0] pin_c = 8'h00;
   logic [7:0] pin_d = 8'h00;
   logic [7:0] ext_rdata = 8'hc3;
   logic [7:0] set_v [8];
   logic [7:0] rdata, ext_addr, ext_wdata, rd_v, rem;
   logic bit_o, ext_rd, ext_wr, bt_v;
   logic [7:0] regs [64];
   iod_req_t req;
   int n_fail, comparisons, cycles, hb;
   logic [5:0] rw_a [12] = '{6'h04, 6'h08, 6'h1d, 6'h1e, 6'h22, 6'h23, 6'h24, 6'h25,
      6'h2b, 6'h33, 6'h35, 6'h37};
   logic [7:0] rw_m [12] = '{8'hff, 8'h7f, 8'h03, 8'hff, 8'hff, 8'h83, 8'hf3, 8'hcf,
      8'hff, 8'h0f, 8'h73, 8'hdf};
   logic [5:0] w_a [8] = '{6'h15, 6'h16, 6'h17, 6'h1b, 6'h1c, 6'h2d, 6'h30, 6'h34};
   logic [7:0] w_m [8] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03, 8'hc0, 8'h10, 8'h0f};

   iod_decoder iod_decoder_i (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
      .pin_b_in(pin_b), .pin_c_in(pin_c), .pin_d_in(pin_d), .t0_set_in(set_v[0]),
      .t1_set_in(set_v[1]), .t2_set_in(set_v[2]), .pc_set_in(set_v[3]),
      .ext_set_in(set_v[4]), .sp_set_in(set_v[5]), .cmp_set_in(set_v[6]),
      .rst_cause_set_in(set_v[7]), .ext_rdata_in(ext_rdata), .rdata_out(rdata),
      .bit_out(bit_o), .ext_rd_out(ext_rd), .ext_wr_out(ext_wr), .ext_addr_out(ext_addr),
      .ext_wdata_out(ext_wdata), .regs_out(regs));

   iod_core_model iod_core_model_i (.clk_in(clk_in), .rdata_in(rdata), .bit_in(bit_o),
      .req_out(req));

   // ==========================================================
   // Clock, checking and closing
   // ==========================================================
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic acc(input iod_op_t op, input logic [7:0] a, input logic [2:0] s,
      input logic [7:0] wd);
      iod_core_model_i.access(op, a, s, wd, 8'hff, rd_v, bt_v);
   endtask : acc

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         $display("mismatch at %0t: run hung", $time);
         final_report();
      end
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial
   begin
      foreach (set_v[i]) set_v[i] = 8'h00;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      for (int a = 0; a < 64; a++) check(regs[a], 8'h00);
      // Write through the I/O space, read through the data space, and back.
      foreach (rw_a[i])
      begin
         iod_core_model_i.access(IOD_OP_OUT, {2'b00, rw_a[i]}, 3'h0, 8'hff, rw_m[i], rd_v, bt_v);
         check(regs[rw_a[i]], rw_m[i]);
         acc(IOD_OP_LOAD, 8'(rw_a[i]) + 8'h20, 3'h0, 8'h00);
         check(rd_v, rw_m[i]);
         iod_core_model_i.access(IOD_OP_STORE, 8'(rw_a[i]) + 8'h20, 3'h0, 8'h3c, rw_m[i],
            rd_v, bt_v);
         acc(IOD_OP_IN, {2'b00, rw_a[i]}, 3'h0, 8'h00);
         check(rd_v, 8'h3c & rw_m[i]);
      end
      acc(IOD_OP_OUT, 8'hde, 3'h0, 8'h81);
      check(regs[30], 8'h81);
      acc(IOD_OP_CLR_BIT, 8'h1e, 3'h0, 8'h00);
      check(regs[30], 8'h80);
      acc(IOD_OP_TEST_BIT, 8'h1e, 3'h7, 8'h00);
      check({7'h00, bt_v}, 8'h01);
      acc(IOD_OP_TEST_BIT, 8'h1e, 3'h0, 8'h00);
      check({7'h00, bt_v}, 8'h00);
      acc(IOD_OP_SET_BIT, 8'h2b, 3'h0, 8'h00);
      check(regs[43], 8'h3c);
      acc(IOD_OP_TEST_BIT, 8'h2b, 3'h2, 8'h00);
      check({7'h00, bt_v}, 8'h00);
      acc(IOD_OP_SET_BIT, 8'h05, 3'h3, 8'h00);
      check(regs[5], 8'h08);
      // The extended space is forwarded only for data-space accesses.
      fork
         acc(IOD_OP_STORE, 8'h80, 3'h0, 8'h99);
         begin
            @(posedge clk_in);
            #1;
            check({6'h00, ext_wr, ext_rd}, 8'h02);
            check(ext_addr, 8'h80);
            check(ext_wdata, 8'h99);
         end
      join
      fork
         acc(IOD_OP_IN, 8'h80, 3'h0, 8'h00);
         begin
            @(posedge clk_in);
            #1;
            check({6'h00, ext_wr, ext_rd}, 8'h00);
         end
      join
      check(rd_v, 8'h00);
      fork
         acc(IOD_OP_LOAD, 8'hf0, 3'h0, 8'h00);
         begin
            @(posedge clk_in);
            #1;
            check({6'h00, ext_wr, ext_rd}, 8'h01);
            check(ext_addr, 8'hf0);
         end
      join
      check(rd_v, 8'hc3);
      acc(IOD_OP_LOAD, 8'h10, 3'h0, 8'h00);
      check(rd_v, 8'h00);
      acc(IOD_OP_IN, 8'h0c, 3'h0, 8'h00);
      check(rd_v, 8'h00);
      acc(IOD_OP_LOAD, 8'h56, 3'h0, 8'h00);
      check(rd_v, 8'h00);
      // Pin registers follow the synchronised pins and ignore writes.
      @(posedge clk_in);
      pin_b <= 8'ha5;
      pin_c <= 8'hff;
      pin_d <= 8'h3c;
      repeat (6) @(posedge clk_in);
      acc(IOD_OP_OUT, 8'h03, 3'h0, 8'h11);
      acc(IOD_OP_IN, 8'h03, 3'h0, 8'h00);
      check(rd_v, 8'ha5);
      acc(IOD_OP_LOAD, 8'h26, 3'h0, 8'h00);
      check(rd_v, 8'h7f);
      acc(IOD_OP_IN, 8'h09, 3'h0, 8'h00);
      check(rd_v, 8'h3c);
      // Hardware sets each register's flags, then software clears the lowest by word write and, below 0x20, the highest by bit set.
      foreach (w_a[i])
      begin
         @(posedge clk_in);
         set_v[i] <= 8'hff;
         @(posedge clk_in);
         set_v[i] <= 8'h00;
         acc(IOD_OP_LOAD, 8'(w_a[i]) + 8'h20, 3'h0, 8'h00);
         check(rd_v, w_m[i]);
         acc(IOD_OP_OUT, {2'b00, w_a[i]}, 3'h0, w_m[i] & (~w_m[i] + 8'h01));
         rem = w_m[i] & (w_m[i] - 8'h01);
         check(regs[w_a[i]], rem);
         if (w_a[i] <= IOD_BIT_TOP)
         begin
            for (int b = 0; b < 8; b++) if (rem[b]) hb = b;
            acc(IOD_OP_CLR_BIT, {2'b00, w_a[i]}, 3'(hb), 8'h00);
            check(regs[w_a[i]], rem);
            acc(IOD_OP_TEST_BIT, {2'b00, w_a[i]}, 3'(hb), 8'h00);
            check({7'h00, bt_v}, 8'h01);
            acc(IOD_OP_SET_BIT, {2'b00, w_a[i]}, 3'(hb), 8'h00);
            check(regs[w_a[i]], rem & ~(8'h01 << hb));
         end
      end
      final_report();
   end
endmodule : tb_iod_decoder
